//--- design/lockin_cmd_regs.vh
// Purpose: shared codes, limits, reset values and timing counts for the command decoder
// Assumes: commands arrive already parsed into an opcode and up to two integer operands
// Notes: opcode values are local encodings of the parsed command letters
`ifndef LOCKIN_CMD_REGS_VH
`define LOCKIN_CMD_REGS_VH

// ==========================================
// command opcodes
`define OP_DISPLAY 5'h00
`define OP_METER 5'h01
`define OP_MAGNIFY 5'h02
`define OP_ZERO_SHIFT 5'h03
`define OP_RESERVE 5'h04
`define OP_BAND 5'h05
`define OP_REFERENCE 5'h06
`define OP_PHASE 5'h07
`define OP_FILTER 5'h08
`define OP_GAIN_RANGE 5'h09
`define OP_RANGE_LIMIT 5'h0A
`define OP_AUTORANGE 5'h0B
`define OP_AUTOSETUP 5'h0C
`define OP_AUTOZERO 5'h0D
`define OP_AUTONORM 5'h0E
`define OP_AUTOPHASE 5'h0F
`define OP_READ_CH1 5'h10
`define OP_READ_CH2 5'h11
`define OP_READ_AUX 5'h12
`define OP_SCALING 5'h13

// ==========================================
// operand limits
`define MAX_DISPLAY 16'h0005
`define MAX_METER 16'h0003
`define MAX_BIT 16'h0001
`define MAX_OFFSET 16'h03E8
`define MAX_CODE2 16'h0002
`define MIN_FREQ 16'h0064
`define MAX_FREQ 16'h03E8
`define MAX_REF_MODE 16'h0007
`define MAX_QUADRANT 16'h0003
`define MIN_PHASE_FINE 16'h0064
`define MAX_PHASE_FINE 16'h0F3C
`define MAX_TC 16'h000A
`define MAX_SENS 16'h0014
`define MAX_SCALE 16'h0FFF
`define FULL_SCALE 16'h07D0
`define OVER_RANGE 16'h0960

// ==========================================
// reset values
`define RST_SCALE 12'h0666
`define RST_FREQ 10'h064
`define RST_PHASE_FINE 12'h0C8
`define RST_SENS 5'h00
`define RST_TC 4'h4

// ==========================================
// reading pacing: 40 ms at 250 MHz
`define READ_MS 40
`define CLK_KHZ 250000
`define READ_CYCLES (`READ_MS * `CLK_KHZ)

`endif

//--- design/read_pacer.v
// Purpose: paces channel readings so one completes no faster than the reading interval
// Assumes: start is a single cycle pulse while idle
// Notes: interval is a parameter so simulation may shorten it
`default_nettype none

module read_pacer #(
    parameter [31:0] interval = 32'd10_000_000
)(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // request
    input wire start,
    output reg busy,
    output reg done
);

reg [31:0] count;

// ==========================================
// interval counter
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        count <= 32'h0000_0000;
        busy <= 1'b0;
        done <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        if (start && !busy)
        begin
            busy <= 1'b1;
            count <= interval - 32'h0000_0001;
        end
        else if (busy)
        begin
            if (count == 32'h0000_0000)
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            else
                count <= count - 32'h0000_0001;
        end
    end
end

endmodule // read_pacer
`default_nettype wire

//--- design/lockin_remote_command_decoder.v
// Purpose: applies parsed remote commands to instrument settings and answers queries
// Assumes: operands are integers already converted from text; measurement values come from outside
// Notes: one command at a time; cmd_ready low while a reading is being paced
//
// Operation
// - operand present sets the function; no operand returns the setting; integers only
// - display select 0..5 picks readout; 5 auxiliary, 4 internal frequency
// - meter select works only on the two-channel variant
// - magnify on for 1, off for 0
// - offset magnitude 0..1000 in tenths of a percent
// - offset mode: 0 off, 1 positive, 2 negative
// - reserve: 0 high reserve, 1 normal, 2 high stability
// - band: 0 broadband, 1 audio, 2 low
// - internal oscillator frequency 100..1000, 0.1% steps of band top
// - reference mode 0..5 internal decades, 6 external fundamental, 7 second harmonic
// - phase quadrant 0..3, fine 100..3900, shift 90q plus 0.025(fine-200)
// - time constant code 0..10, 100 s downward
// - rolloff 12 dB/octave for 0, 6 dB/octave for 1
// - sensitivity code 0..20, 5 V down to 1 uV
// - autorange limit uses the same 0..20 scale
// - autorange and autosetup on for 1, off for 0
// - autozero starts offset routine; offset 0,0 stops it
// - auto normalization on for 1, off for 0
// - autophase: two-channel ranges then phases; single-channel advances one of three steps
// - readings scaled so +-2000 is full scale, valid to 20% beyond; over_range is set above 2000 (FULL_SCALE), not 2400
// - one first-channel reading per 40 ms; alternating reads every 80 ms
// - scaling 0..4095, default 1638, gain is value over 1638
`default_nettype none
`include "lockin_cmd_regs.vh"

module lockin_remote_command_decoder #(
    parameter [31:0] read_cycles = `READ_CYCLES
)(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // variant strap
    input wire two_channel,
    // parsed command
    input wire cmd_valid,
    input wire [4:0] cmd_op,
    input wire [1:0] cmd_argc,
    input wire [15:0] cmd_arg1,
    input wire [15:0] cmd_arg2,
    output reg cmd_ready,
    // answer
    output reg resp_valid,
    output reg resp_error,
    output reg [15:0] resp_data1,
    output reg [15:0] resp_data2,
    // measurements, signed, scaled +-2000 full scale
    input wire [15:0] meas_ch1,
    input wire [15:0] meas_ch2,
    input wire [15:0] meas_aux,
    // settings
    output reg [2:0] display_sel,
    output reg [1:0] meter_sel,
    output reg magnify_on,
    output reg [9:0] offset_level,
    output reg [1:0] offset_mode,
    output reg [1:0] reserve_sel,
    output reg [1:0] band_sel,
    output reg [9:0] osc_freq,
    output reg [2:0] ref_mode,
    output reg [1:0] phase_quadrant,
    output reg [11:0] phase_fine,
    output reg [3:0] time_const,
    output reg rolloff_6db,
    output reg [4:0] sensitivity,
    output reg [4:0] range_limit,
    output reg autorange_on,
    output reg autosetup_on,
    output reg autozero_on,
    output reg auto_normalization,
    output reg [11:0] gain_scale,
    // routine strobes, autophase step and over-range flag
    output reg autozero_start,
    output reg autophase_range_start,
    output reg autophase_start,
    output reg [1:0] autophase_step,
    output reg over_range
);

localparam [2:0] st_idle = 3'b001;
localparam [2:0] st_wait = 3'b010;
localparam [2:0] st_send = 3'b100;

reg [2:0] state;
reg [2:0] next_state;
reg [1:0] read_src;
reg pace_start;
wire pace_busy;
wire pace_done;
wire set_req;
wire take;
reg ok;
reg [15:0] q1;
reg [15:0] q2;
reg [15:0] sample;
wire [15:0] mag;

assign set_req = (cmd_argc != 2'd0);
assign take = cmd_valid && cmd_ready;

// ==========================================
// operand range check
always @*
begin
    ok = 1'b1;
    case (cmd_op)
        `OP_DISPLAY: ok = cmd_arg1 <= `MAX_DISPLAY;
        `OP_METER: ok = two_channel && cmd_arg1 <= `MAX_METER;
        `OP_MAGNIFY, `OP_AUTORANGE, `OP_AUTOSETUP, `OP_AUTONORM: ok = cmd_arg1 <= `MAX_BIT;
        `OP_ZERO_SHIFT: ok = cmd_argc == 2'd2 && cmd_arg1 <= `MAX_OFFSET && cmd_arg2 <= `MAX_CODE2;
        `OP_RESERVE, `OP_BAND: ok = cmd_arg1 <= `MAX_CODE2;
        `OP_REFERENCE: ok = cmd_argc == 2'd2 && cmd_arg1 >= `MIN_FREQ && cmd_arg1 <= `MAX_FREQ
            && cmd_arg2 <= `MAX_REF_MODE;
        `OP_PHASE: ok = cmd_argc == 2'd2 && cmd_arg1 <= `MAX_QUADRANT && cmd_arg2 >= `MIN_PHASE_FINE
            && cmd_arg2 <= `MAX_PHASE_FINE;
        `OP_FILTER: ok = cmd_argc == 2'd2 && cmd_arg1 <= `MAX_TC && cmd_arg2 <= `MAX_BIT;
        `OP_GAIN_RANGE, `OP_RANGE_LIMIT: ok = cmd_arg1 <= `MAX_SENS;
        `OP_SCALING: ok = cmd_arg1 <= `MAX_SCALE;
        `OP_AUTOZERO, `OP_AUTOPHASE, `OP_READ_CH1, `OP_READ_AUX: ok = 1'b1;
        `OP_READ_CH2: ok = two_channel;
        default: ok = 1'b0;
    endcase
end

// ==========================================
// read-back of current settings
always @*
begin
    q1 = 16'h0000;
    q2 = 16'h0000;
    case (cmd_op)
        `OP_DISPLAY: q1 = {13'h0000, display_sel};
        `OP_METER: q1 = {14'h0000, meter_sel};
        `OP_MAGNIFY: q1 = {15'h0000, magnify_on};
        `OP_ZERO_SHIFT:
        begin
            q1 = {6'h00, offset_level};
            q2 = {14'h0000, offset_mode};
        end
        `OP_RESERVE: q1 = {14'h0000, reserve_sel};
        `OP_BAND: q1 = {14'h0000, band_sel};
        `OP_REFERENCE:
        begin
            q1 = {6'h00, osc_freq};
            q2 = {13'h0000, ref_mode};
        end
        `OP_PHASE:
        begin
            q1 = {14'h0000, phase_quadrant};
            q2 = {4'h0, phase_fine};
        end
        `OP_FILTER:
        begin
            q1 = {12'h000, time_const};
            q2 = {15'h0000, rolloff_6db};
        end
        `OP_GAIN_RANGE: q1 = {11'h000, sensitivity};
        `OP_RANGE_LIMIT: q1 = {11'h000, range_limit};
        `OP_AUTORANGE: q1 = {15'h0000, autorange_on};
        `OP_AUTOSETUP: q1 = {15'h0000, autosetup_on};
        `OP_AUTONORM: q1 = {15'h0000, auto_normalization};
        `OP_SCALING: q1 = {4'h0, gain_scale};
        default: q1 = 16'h0000;
    endcase
end

// ==========================================
// reading source and over-range flag
always @*
begin
    case (read_src)
        2'd1: sample = meas_ch2;
        2'd2: sample = meas_aux;
        default: sample = meas_ch1;
    endcase
end

assign mag = sample[15] ? (16'h0000 - sample) : sample;

// ==========================================
// sequencer
always @*
begin
    next_state = state;
    pace_start = 1'b0;
    case (state)
        st_idle:
        begin
            if (take && (cmd_op == `OP_READ_CH1 || (cmd_op == `OP_READ_CH2 && two_channel)))
            begin
                next_state = st_wait;
                pace_start = 1'b1;
            end
        end
        st_wait:
        begin
            if (pace_done)
                next_state = st_send;
        end
        st_send: next_state = st_idle;
        default: next_state = st_idle;
    endcase
end

read_pacer #(
    .interval(read_cycles)
) u_pacer (
    .clk(clk),
    .rst_n(rst_n),
    .start(pace_start),
    .busy(pace_busy),
    .done(pace_done)
);

// ==========================================
// settings and answers
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        state <= st_idle;
        cmd_ready <= 1'b0;
        read_src <= 2'd0;
        resp_valid <= 1'b0;
        resp_error <= 1'b0;
        resp_data1 <= 16'h0000;
        resp_data2 <= 16'h0000;
        display_sel <= 3'd0;
        meter_sel <= 2'd0;
        magnify_on <= 1'b0;
        offset_level <= 10'd0;
        offset_mode <= 2'd0;
        reserve_sel <= 2'd1;
        band_sel <= 2'd0;
        osc_freq <= `RST_FREQ;
        ref_mode <= 3'd6;
        phase_quadrant <= 2'd0;
        phase_fine <= `RST_PHASE_FINE;
        time_const <= `RST_TC;
        rolloff_6db <= 1'b0;
        sensitivity <= `RST_SENS;
        range_limit <= `RST_SENS;
        autorange_on <= 1'b0;
        autosetup_on <= 1'b0;
        autozero_on <= 1'b0;
        auto_normalization <= 1'b0;
        gain_scale <= `RST_SCALE;
        autozero_start <= 1'b0;
        autophase_range_start <= 1'b0;
        autophase_start <= 1'b0;
        autophase_step <= 2'd0;
        over_range <= 1'b0;
    end
    else
    begin
        state <= next_state;
        cmd_ready <= (next_state == st_idle) && !pace_busy;
        resp_valid <= 1'b0;
        autozero_start <= 1'b0;
        autophase_range_start <= 1'b0;
        autophase_start <= 1'b0;
        if (state == st_send)
        begin
            resp_valid <= 1'b1;
            resp_error <= 1'b0;
            resp_data1 <= sample;
            resp_data2 <= 16'h0000;
            over_range <= mag > `FULL_SCALE;
        end
        if (take)
        begin
            cmd_ready <= 1'b0;
            resp_data2 <= 16'h0000;
            if (cmd_op == `OP_READ_CH1 || cmd_op == `OP_READ_CH2 || cmd_op == `OP_READ_AUX)
            begin
                read_src <= cmd_op[1:0];
                if (!ok)
                begin
                    resp_valid <= 1'b1;
                    resp_error <= 1'b1;
                end
                else if (cmd_op == `OP_READ_AUX)
                begin
                    resp_valid <= 1'b1;
                    resp_error <= 1'b0;
                    resp_data1 <= meas_aux;
                    over_range <= (meas_aux[15] ? (16'h0000 - meas_aux) : meas_aux) > `FULL_SCALE;
                end
            end
            else if (!set_req && cmd_op != `OP_AUTOZERO && cmd_op != `OP_AUTOPHASE)
            begin
                resp_valid <= 1'b1;
                resp_error <= (cmd_op == `OP_METER) ? !two_channel : (cmd_op > `OP_SCALING);
                resp_data1 <= q1;
                resp_data2 <= q2;
            end
            else
            begin
                resp_valid <= 1'b1;
                resp_error <= !ok;
                resp_data1 <= 16'h0000;
                if (ok)
                begin
                    case (cmd_op)
                        `OP_DISPLAY: display_sel <= cmd_arg1[2:0];
                        `OP_METER: meter_sel <= cmd_arg1[1:0];
                        `OP_MAGNIFY: magnify_on <= cmd_arg1[0];
                        `OP_ZERO_SHIFT:
                        begin
                            offset_level <= cmd_arg1[9:0];
                            offset_mode <= cmd_arg2[1:0];
                            if (cmd_arg1 == 16'h0000 && cmd_arg2 == 16'h0000)
                                autozero_on <= 1'b0;
                        end
                        `OP_RESERVE: reserve_sel <= cmd_arg1[1:0];
                        `OP_BAND: band_sel <= cmd_arg1[1:0];
                        `OP_REFERENCE:
                        begin
                            osc_freq <= cmd_arg1[9:0];
                            ref_mode <= cmd_arg2[2:0];
                        end
                        `OP_PHASE:
                        begin
                            phase_quadrant <= cmd_arg1[1:0];
                            phase_fine <= cmd_arg2[11:0];
                        end
                        `OP_FILTER:
                        begin
                            time_const <= cmd_arg1[3:0];
                            rolloff_6db <= cmd_arg2[0];
                        end
                        `OP_GAIN_RANGE: sensitivity <= cmd_arg1[4:0];
                        `OP_RANGE_LIMIT: range_limit <= cmd_arg1[4:0];
                        `OP_AUTORANGE: autorange_on <= cmd_arg1[0];
                        `OP_AUTOSETUP: autosetup_on <= cmd_arg1[0];
                        `OP_AUTOZERO:
                        begin
                            autozero_on <= 1'b1;
                            autozero_start <= 1'b1;
                        end
                        `OP_AUTONORM: auto_normalization <= cmd_arg1[0];
                        `OP_AUTOPHASE:
                        begin
                            if (two_channel)
                            begin
                                autophase_range_start <= 1'b1;
                                autophase_start <= 1'b1;
                            end
                            else
                            begin
                                autophase_start <= 1'b1;
                                autophase_step <= (autophase_step == 2'd2) ? 2'd0 : autophase_step + 2'd1;
                            end
                        end
                        `OP_SCALING: gain_scale <= cmd_arg1[11:0];
                        default: resp_error <= 1'b1;
                    endcase
                end
            end
        end
    end
end

endmodule // lockin_remote_command_decoder
`default_nettype wire

//--- verif/host_model.sv
// Purpose: host side model that issues parsed commands and collects answers
// Assumes: one command outstanding at a time
// Notes: released operand lines show the inverse of their last value
`default_nettype none

module host_model (
    // clock
    input wire logic clk,
    // command lines
    output logic cmd_valid,
    output logic [4:0] cmd_op,
    output logic [1:0] cmd_argc,
    output logic [15:0] cmd_arg1,
    output logic [15:0] cmd_arg2,
    input wire logic cmd_ready,
    // answer lines
    input wire logic resp_valid,
    input wire logic resp_error,
    input wire logic [15:0] resp_data1,
    input wire logic [15:0] resp_data2
);
    timeunit 1ns;
    timeprecision 1ps;

    logic r_err;
    logic [15:0] r_d1;
    logic [15:0] r_d2;
    int lat;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_op = 5'h1f;
        cmd_argc = 2'h0;
        cmd_arg1 = 16'h0000;
        cmd_arg2 = 16'h0000;
    end

    // ==========================================
    // one command, held until taken
    task send(input logic [4:0] op, input int n, input int a, input int b);
        int i;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_argc <= 2'(n);
        cmd_arg1 <= 16'(a);
        cmd_arg2 <= 16'(b);
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (cmd_ready !== 1'b1 && i < 200);
        cmd_valid <= 1'b0;
        cmd_arg1 <= ~16'(a);
        cmd_arg2 <= ~16'(b);
        lat = 0;
        do
        begin
            @(posedge clk);
            lat++;
        end
        while (resp_valid !== 1'b1 && lat < 200);
        r_err = resp_error;
        r_d1 = resp_data1;
        r_d2 = resp_data2;
        // a command never taken or never answered poisons the error flag
        if (i >= 200 || lat >= 200)
            r_err = 1'bx;
    endtask
endmodule // host_model

`default_nettype wire

//--- verif/lockin_cmd_assertions.sv
// Purpose: port level checks of the command decoder
// Assumes: one clock, asynchronous active low reset
// Notes: bound to every decoder instance
`default_nettype none
`include "lockin_cmd_regs.vh"

module decoder_checker #(
    parameter int read_cycles = 20
)(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // command and answer
    input wire two_channel,
    input wire cmd_valid,
    input wire [4:0] cmd_op,
    input wire [1:0] cmd_argc,
    input wire [15:0] cmd_arg1,
    input wire [15:0] cmd_arg2,
    input wire cmd_ready,
    input wire resp_valid,
    input wire resp_error,
    // settings
    input wire [2:0] display_sel,
    input wire [1:0] meter_sel,
    input wire magnify_on,
    input wire [1:0] offset_mode,
    input wire [1:0] reserve_sel,
    input wire autozero_on,
    input wire autozero_start,
    input wire autophase_range_start,
    input wire autophase_start
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int ANSWER_AT = read_cycles + 3;
    wire take;
    assign take = cmd_valid && cmd_ready;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================
    // named steps
    sequence s_ch1_take;
        take && cmd_op == `OP_READ_CH1;
    endsequence
    sequence s_az_take;
        take && cmd_op == `OP_AUTOZERO;
    endsequence

    // ==========================================
    // checks
    AST_RESP_PULSE: assert property (resp_valid |=> !resp_valid)
        else $error("answer strobe longer than one cycle");
    AST_READY_DROP: assert property (take |=> !cmd_ready)
        else $error("ready stayed high after a take");
    AST_DISPLAY_SET: assert property (take && cmd_op == `OP_DISPLAY && cmd_argc == 2'h1
        && cmd_arg1 <= `MAX_DISPLAY |=> resp_valid && !resp_error && 16'(display_sel) == $past(cmd_arg1))
        else $error("display select not applied");
    AST_RESERVE_REJECT: assert property (take && cmd_op == `OP_RESERVE && cmd_argc == 2'h1
        && cmd_arg1 > `MAX_CODE2 |=> resp_error && $stable(reserve_sel))
        else $error("bad reserve code not refused");
    AST_MAGNIFY: assert property (take && cmd_op == `OP_MAGNIFY && cmd_argc == 2'h1
        && cmd_arg1 <= `MAX_BIT |=> 16'(magnify_on) == $past(cmd_arg1))
        else $error("magnify not switched");
    AST_METER_SINGLE: assert property (take && cmd_op == `OP_METER && !two_channel
        |=> resp_error && $stable(meter_sel))
        else $error("meter command acted on single channel");
    AST_READ_HOLD: assert property (s_ch1_take |=> (!cmd_ready && !resp_valid) [*8])
        else $error("reading answered too early");
    AST_READ_ANSWER: assert property (s_ch1_take |-> ##ANSWER_AT resp_valid)
        else $error("reading answer late");
    AST_ZERO_OFF: assert property (take && cmd_op == `OP_ZERO_SHIFT && cmd_argc == 2'h2
        && cmd_arg1 == 16'h0000 && cmd_arg2 == 16'h0000 |=> !autozero_on && offset_mode == 2'h0)
        else $error("offset 0,0 left auto offset on");
    AST_AUTOZERO_PULSE: assert property (s_az_take |=> autozero_start ##1 !autozero_start)
        else $error("auto offset start strobe wrong");
    AST_PHASE_TWO: assert property (take && cmd_op == `OP_AUTOPHASE && two_channel
        |=> autophase_range_start && autophase_start)
        else $error("autophase did not range first");
endmodule // decoder_checker

bind lockin_remote_command_decoder decoder_checker #(.read_cycles(read_cycles)) chk_i (
    .clk, .rst_n, .two_channel, .cmd_valid, .cmd_op, .cmd_argc, .cmd_arg1, .cmd_arg2, .cmd_ready,
    .resp_valid, .resp_error, .display_sel, .meter_sel, .magnify_on, .offset_mode, .reserve_sel,
    .autozero_on, .autozero_start, .autophase_range_start, .autophase_start);

`default_nettype wire

//--- verif/testbench.sv
// Purpose: directed command sequences against the decoder
// Assumes: pacing shortened to a few cycles
// Notes: settings observed on the instance ports
`default_nettype none
`include "lockin_cmd_regs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PACE = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic two_channel = 1'b0;
    logic [15:0] meas_ch1 = 16'hF830;
    logic [15:0] meas_ch2 = 16'h07D0;
    logic [15:0] meas_aux = 16'h0123;
    logic cmd_valid, cmd_ready, resp_valid, resp_error;
    logic [4:0] cmd_op;
    logic [1:0] cmd_argc;
    logic [15:0] cmd_arg1, cmd_arg2, resp_data1, resp_data2;
    logic [4:0] sw_op [4] = '{`OP_MAGNIFY, `OP_AUTORANGE, `OP_AUTOSETUP, `OP_AUTONORM};
    wire [3:0] sw_state = {uut.auto_normalization, uut.autosetup_on, uut.autorange_on, uut.magnify_on};
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_argc(cmd_argc),
        .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_error(resp_error), .resp_data1(resp_data1), .resp_data2(resp_data2));

    lockin_remote_command_decoder #(.read_cycles(PACE)) uut (.clk(clk), .rst_n(rst_n),
        .two_channel(two_channel), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_argc(cmd_argc),
        .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_error(resp_error), .resp_data1(resp_data1), .resp_data2(resp_data2),
        .meas_ch1(meas_ch1), .meas_ch2(meas_ch2), .meas_aux(meas_aux), .display_sel(), .meter_sel(),
        .magnify_on(), .offset_level(), .offset_mode(), .reserve_sel(), .band_sel(), .osc_freq(),
        .ref_mode(), .phase_quadrant(), .phase_fine(), .time_const(), .rolloff_6db(), .sensitivity(),
        .range_limit(), .autorange_on(), .autosetup_on(), .autozero_on(), .auto_normalization(),
        .gain_scale(), .autozero_start(), .autophase_range_start(), .autophase_start(),
        .autophase_step(), .over_range());

    // ==========================================
    // compare, command and closing tasks
    task chk(input logic [15:0] got, input int exp);
        cmp_count++;
        if (got !== 16'(exp))
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, 16'(exp));
        end
    endtask

    task cmd(input logic [4:0] op, input int n, input int a, input int b, input int e);
        host.send(op, n, a, b);
        chk(16'(host.r_err), e);
    endtask

    task results;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            results();
        end
    end

    // ==========================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        chk(16'(uut.gain_scale), 1638);
        chk(16'(uut.ref_mode), 6);
        for (int k = 0; k <= 5; k++)
        begin
            cmd(`OP_DISPLAY, 1, k, 0, 0);
            chk(16'(uut.display_sel), k);
        end
        cmd(`OP_DISPLAY, 1, 6, 0, 1);
        cmd(`OP_DISPLAY, 0, 0, 0, 0);
        chk(host.r_d1, 5);
        for (int k = 0; k <= 2; k++)
        begin
            cmd(`OP_RESERVE, 1, k, 0, 0);
            chk(16'(uut.reserve_sel), k);
            cmd(`OP_BAND, 1, k, 0, 0);
            chk(16'(uut.band_sel), k);
        end
        cmd(`OP_RESERVE, 1, 3, 0, 1);
        cmd(`OP_BAND, 1, 3, 0, 1);
        for (int k = 0; k <= 7; k++)
        begin
            cmd(`OP_REFERENCE, 2, (k > 5) ? 100 : 1000, k, 0);
            chk(16'(uut.ref_mode), k);
        end
        cmd(`OP_REFERENCE, 2, 100, 2, 0);
        cmd(`OP_REFERENCE, 2, 99, 2, 1);
        cmd(`OP_REFERENCE, 2, 1001, 1, 1);
        cmd(`OP_REFERENCE, 2, 1000, 8, 1);
        cmd(`OP_REFERENCE, 1, 1000, 0, 1);
        chk(16'(uut.osc_freq), 100);
        chk(16'(uut.ref_mode), 2);
        cmd(`OP_ZERO_SHIFT, 2, 1000, 2, 0);
        cmd(`OP_ZERO_SHIFT, 2, 1001, 1, 1);
        cmd(`OP_ZERO_SHIFT, 2, 0, 3, 1);
        cmd(`OP_ZERO_SHIFT, 0, 0, 0, 0);
        chk(host.r_d1, 1000);
        chk(host.r_d2, 2);
        cmd(`OP_AUTOZERO, 0, 0, 0, 0);
        chk(16'(uut.autozero_on), 1);
        cmd(`OP_ZERO_SHIFT, 2, 0, 0, 0);
        chk(16'(uut.autozero_on), 0);
        cmd(`OP_PHASE, 2, 3, 3900, 0);
        cmd(`OP_PHASE, 2, 4, 200, 1);
        cmd(`OP_PHASE, 2, 0, 99, 1);
        cmd(`OP_PHASE, 0, 0, 0, 0);
        chk(host.r_d1, 3);
        chk(host.r_d2, 3900);
        cmd(`OP_FILTER, 2, 10, 1, 0);
        cmd(`OP_FILTER, 2, 11, 0, 1);
        cmd(`OP_FILTER, 2, 0, 2, 1);
        chk(16'(uut.time_const), 10);
        chk(16'(uut.rolloff_6db), 1);
        cmd(`OP_GAIN_RANGE, 1, 20, 0, 0);
        cmd(`OP_GAIN_RANGE, 1, 21, 0, 1);
        chk(16'(uut.sensitivity), 20);
        cmd(`OP_RANGE_LIMIT, 1, 20, 0, 0);
        cmd(`OP_RANGE_LIMIT, 1, 21, 0, 1);
        chk(16'(uut.range_limit), 20);
        for (int k = 0; k < 4; k++)
        begin
            cmd(sw_op[k], 1, 1, 0, 0);
            chk(16'(sw_state[k]), 1);
            cmd(sw_op[k], 1, 2, 0, 1);
            cmd(sw_op[k], 1, 0, 0, 0);
            chk(16'(sw_state[k]), 0);
        end
        cmd(`OP_SCALING, 1, 4095, 0, 0);
        cmd(`OP_SCALING, 1, 4096, 0, 1);
        chk(16'(uut.gain_scale), 4095);
        cmd(`OP_METER, 1, 1, 0, 1);
        cmd(`OP_READ_CH2, 0, 0, 0, 1);
        for (int k = 1; k <= 3; k++)
        begin
            cmd(`OP_AUTOPHASE, 0, 0, 0, 0);
            chk(16'(uut.autophase_step), k % 3);
        end
        cmd(`OP_READ_CH1, 0, 0, 0, 0);
        chk(host.r_d1, 16'hF830);
        chk(16'(host.lat), PACE + 3);
        chk(16'(uut.over_range), 0);
        meas_ch1 <= 16'h07D1;
        cmd(`OP_READ_CH1, 0, 0, 0, 0);
        chk(16'(uut.over_range), 1);
        cmd(`OP_READ_AUX, 0, 0, 0, 0);
        chk(host.r_d1, 16'h0123);
        two_channel <= 1'b1;
        cmd(`OP_METER, 1, 3, 0, 0);
        cmd(`OP_METER, 1, 4, 0, 1);
        chk(16'(uut.meter_sel), 3);
        cmd(`OP_READ_CH2, 0, 0, 0, 0);
        chk(host.r_d1, 16'h07D0);
        chk(16'(host.lat), PACE + 3);
        cmd(`OP_AUTOPHASE, 0, 0, 0, 0);
        repeat (2) @(posedge clk);
        results();
    end
endmodule // testbench

`default_nettype wire
